// ---- design/wrs_hold.sv ----
`timescale 1ns/1ps
module wrs_hold #(
    parameter int HOLD = 4
) (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // request and stretched answer
    wrs_hold_if.tmr   hold
);
    localparam int             CW     = $clog2(HOLD + 1);
    localparam logic [CW-1:0]  HOLD_V = CW'(HOLD);

    logic [CW-1:0] cnt_q;

    // active from the cycle after req, for HOLD cycles after req's last cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q <= '0;
        end else if (hold.req) begin
            cnt_q <= HOLD_V;
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
        end
    end

    assign hold.active = (cnt_q != '0);
endmodule : wrs_hold

// ---- design/wrs_hold_if.sv ----
`timescale 1ns/1ps
// request into a stretch timer and its stretched answer
interface wrs_hold_if;
    logic req;
    logic active;
    modport src (output req, input active);
    modport tmr (input req, output active);
endinterface : wrs_hold_if

// ---- design/wrs_pkg.sv ----
// Overview of operation
// R1: low supply resets; held 10 ms after recovery
// R2: low-voltage reset on at power-up; software disables
// R3: low-voltage logic runs in idle and power-down
// R4: supply dips under 1 us are ignored
// R5: four to eight SE0 samples set bus-reset flag
// R6: bus-reset enable bit 6 also resets the core
// R7: watchdog is 22-bit, one step per machine cycle
// R8: watchdog overflow at terminal count makes a reset
// R9: reload write loads seven counter MSBs; bit 7 reserved
// R10: reload write also clears fifteen counter LSBs
// R11: software reloads with at most 7Eh before overflow
// R12: only key 55h stops the watchdog
// R13: watchdog enabled at power-up and every reset
// R14: watchdog and reset logic active in idle
// R15: software wakes periodically from idle to reload
// R16: watchdog reset lasts 2^15 machine cycles
// R17: internal reset ORs all sources; re-enables watchdog
package wrs_pkg;
    // machine-cycle clock
    localparam int CLK_PERIOD_NS   = 4;
    localparam int LVR_HOLD_NS     = 10_000_000;
    localparam int LVR_HOLD_CYC    = (LVR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LVR_FILT_NS     = 1_000;
    localparam int LVR_FILT_CYC    = (LVR_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LVR_FILT_W      = 9;
    localparam int WDT_WIDTH       = 22;
    localparam int WDT_RELOAD_BITS = 7;
    localparam int WDT_PULSE_CYC   = 32768;
    localparam int SE0_MIN         = 4;
    localparam int SE0_MAX         = 8;
    localparam int SE0_W           = 4;

    localparam logic [7:0] WDT_KEY_OFF = 8'h55;
    localparam logic [7:0] KEY_RST     = 8'h00;

    // register indices; byte address is four times the index
    localparam int          ADDR_W          = 10;
    localparam logic [7:0]  REG_WDT_RELOAD  = 8'hA6;
    localparam logic [7:0]  REG_WDT_KEY     = 8'hAE;
    localparam logic [7:0]  REG_PWR_CTL     = 8'h87;
    localparam logic [7:0]  REG_USB_STA     = 8'hB0;
    localparam logic [7:0]  REG_USB_EN      = 8'hB1;
    localparam logic [7:0]  REG_IRQ_STA     = 8'hB2;
    localparam logic [7:0]  REG_IRQ_CLR     = 8'hB3;
    localparam logic [7:0]  REG_IRQ_EN      = 8'hB4;
    localparam logic [7:0]  REG_WDT_STA     = 8'hB5;

    // field positions
    localparam int PWR_LVD_EN_BIT   = 4;
    localparam int USB_RST_FLAG_BIT = 6;
    localparam int USB_RST_EN_BIT   = 6;
    localparam int WSTA_EN_BIT      = 7;
    localparam int WSTA_IDLE_BIT    = 8;
    localparam int WSTA_PD_BIT      = 9;
    localparam int WSTA_RST_BIT     = 10;

    localparam int IRQ_W   = 4;
    localparam int IRQ_LV  = 0;
    localparam int IRQ_USB = 1;
    localparam int IRQ_WDT = 2;
    localparam int IRQ_EXT = 3;

    localparam logic [7:0] PWR_CTL_RST = 8'h10;
    localparam logic [7:0] USB_EN_RST  = 8'h00;
endpackage : wrs_pkg

// ---- design/wrs_supervisor.sv ----
`timescale 1ns/1ps
module wrs_supervisor #(
    parameter int LVR_HOLD_CYC  = wrs_pkg::LVR_HOLD_CYC,
    parameter int WDT_PULSE_CYC = wrs_pkg::WDT_PULSE_CYC,
    parameter int WDT_WIDTH     = wrs_pkg::WDT_WIDTH
) (
    // clock and power-on reset
    input  wire logic                       clk_i,
    input  wire logic                       rst_i,
    // wishbone classic slave
    input  wire logic                       wb_cyc_i,
    input  wire logic                       wb_stb_i,
    input  wire logic                       wb_we_i,
    input  wire logic [wrs_pkg::ADDR_W-1:0] wb_adr_i,
    input  wire logic [3:0]                 wb_sel_i,
    input  wire logic [31:0]                wb_dat_i,
    output logic      [31:0]                wb_dat_o,
    output logic                            wb_ack_o,
    // reset sources from pins and analog
    input  wire logic                       ext_reset_n_i,
    input  wire logic                       lv_below_i,
    input  wire logic                       usb_se0_i,
    // processor power state
    input  wire logic                       cpu_idle_i,
    input  wire logic                       cpu_powerdown_i,
    // outputs
    output logic                            int_reset_o,
    output logic                            irq_o
);
    localparam int RB = wrs_pkg::WDT_RELOAD_BITS;
    localparam int LB = WDT_WIDTH - RB;

    // ------------------------------------------------ pin synchronisers
    logic ext_rst_n_s;
    logic lv_below_s;
    logic se0_s;
    logic idle_s;
    logic pd_s;

    // the reset pin idles high; a stage resetting low would fake a request after reset
    wrs_sync #(
        .W     (5),
        .RST_V (5'h10)
    ) u_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   ({ext_reset_n_i, lv_below_i, usb_se0_i, cpu_idle_i, cpu_powerdown_i}),
        .q_o   ({ext_rst_n_s, lv_below_s, se0_s, idle_s, pd_s})
    );

    // ------------------------------------------------ register bus
    logic       ack_q;
    logic [31:0] dat_q;
    logic       wr_stb;
    logic [7:0] reg_idx;

    function automatic logic hit(input logic [7:0] idx, input logic [7:0] reg_id);
        hit = (idx == reg_id);
    endfunction : hit

    assign reg_idx = wb_adr_i[wrs_pkg::ADDR_W-1:2];
    // writes land on the edge that sees ack high; only byte lane 0 carries data
    assign wr_stb  = wb_cyc_i & wb_stb_i & wb_we_i & ack_q & wb_sel_i[0];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= wb_cyc_i & wb_stb_i & ~ack_q;
        end
    end

    // ------------------------------------------------ control registers
    logic [7:0] pwr_ctl_q;
    logic [7:0] usb_en_q;
    logic [7:0] key_q;
    logic [wrs_pkg::IRQ_W-1:0] irq_en_q;
    logic       int_rst_q;
    logic       lvd_en;
    logic       usb_rst_en;
    logic       wdt_en;

    // power-up default keeps the low-voltage reset armed
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pwr_ctl_q <= wrs_pkg::PWR_CTL_RST; // [R2]
        end else if (wr_stb && hit(reg_idx, wrs_pkg::REG_PWR_CTL)) begin
            pwr_ctl_q <= wb_dat_i[7:0]; // [R2]
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            usb_en_q <= wrs_pkg::USB_EN_RST;
        end else if (wr_stb && hit(reg_idx, wrs_pkg::REG_USB_EN)) begin
            usb_en_q <= wb_dat_i[7:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_en_q <= '0;
        end else if (wr_stb && hit(reg_idx, wrs_pkg::REG_IRQ_EN)) begin
            irq_en_q <= wb_dat_i[wrs_pkg::IRQ_W-1:0];
        end
    end

    // any internal reset puts the key back, so the watchdog runs again
    always_ff @(posedge clk_i) begin
        if (rst_i || int_rst_q) begin
            key_q <= wrs_pkg::KEY_RST; // [R13] [R17]
        end else if (wr_stb && hit(reg_idx, wrs_pkg::REG_WDT_KEY)) begin
            key_q <= wb_dat_i[7:0];
        end
    end

    assign lvd_en     = pwr_ctl_q[wrs_pkg::PWR_LVD_EN_BIT];
    assign usb_rst_en = usb_en_q[wrs_pkg::USB_RST_EN_BIT];
    assign wdt_en     = (key_q != wrs_pkg::WDT_KEY_OFF); // [R12]

    // ------------------------------------------------ low-voltage detector
    // idle and power-down do not gate this path at all
    logic [wrs_pkg::LVR_FILT_W-1:0] lv_flt_q;
    logic                           lv_det;
    wrs_hold_if                     lv_hold ();

    localparam logic [wrs_pkg::LVR_FILT_W-1:0] LV_FILT_V =
        wrs_pkg::LVR_FILT_W'(wrs_pkg::LVR_FILT_CYC);

    // short dips never reach the terminal count and are forgotten
    always_ff @(posedge clk_i) begin
        if (rst_i || !lv_below_s) begin
            lv_flt_q <= '0; // [R4]
        end else if (lv_flt_q != LV_FILT_V) begin
            lv_flt_q <= lv_flt_q + 1'b1; // [R4] [R3]
        end
    end

    assign lv_det      = (lv_flt_q == LV_FILT_V); // [R4]
    assign lv_hold.req = lv_det & lvd_en; // [R1] [R2]

    wrs_hold #(
        .HOLD (LVR_HOLD_CYC)
    ) u_lv_hold (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .hold  (lv_hold)
    );

    // ------------------------------------------------ usb bus reset
    logic [wrs_pkg::SE0_W-1:0] se0_cnt_q;
    logic                      usb_det;
    logic                      usb_req;
    logic                      usb_flag_q;

    localparam logic [wrs_pkg::SE0_W-1:0] SE0_MIN_V = wrs_pkg::SE0_W'(wrs_pkg::SE0_MIN - 1);
    localparam logic [wrs_pkg::SE0_W-1:0] SE0_MAX_V = wrs_pkg::SE0_W'(wrs_pkg::SE0_MAX);

    // consecutive SE0 samples, saturating so a long reset stays detected
    always_ff @(posedge clk_i) begin
        if (rst_i || !se0_s) begin
            se0_cnt_q <= '0;
        end else if (se0_cnt_q != SE0_MAX_V) begin
            se0_cnt_q <= se0_cnt_q + 1'b1;
        end
    end

    assign usb_det = se0_s && (se0_cnt_q == SE0_MIN_V); // [R5]
    assign usb_req = se0_s && (se0_cnt_q >= SE0_MIN_V) && usb_rst_en; // [R6]

    // write one to clear; a detection in the same cycle wins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            usb_flag_q <= 1'b0;
        end else if (usb_det) begin
            usb_flag_q <= 1'b1; // [R5]
        end else if (wr_stb && hit(reg_idx, wrs_pkg::REG_USB_STA)
                     && wb_dat_i[wrs_pkg::USB_RST_FLAG_BIT]) begin
            usb_flag_q <= 1'b0;
        end
    end

    // ------------------------------------------------ watchdog counter
    logic [WDT_WIDTH-1:0] wdt_cnt_q;
    logic                 wdt_fire;
    logic                 reload_stb;
    wrs_hold_if           wdt_hold ();

    assign reload_stb = wr_stb && hit(reg_idx, wrs_pkg::REG_WDT_RELOAD);
    assign wdt_fire   = wdt_en && (wdt_cnt_q == '1); // [R8]

    // counts through idle; software must reload in time, bit 7 of the
    // written byte is dropped, and a reload wins over the increment
    always_ff @(posedge clk_i) begin
        if (rst_i || int_rst_q) begin
            wdt_cnt_q <= '0; // [R13] [R17]
        end else if (reload_stb) begin
            wdt_cnt_q <= {wb_dat_i[RB-1:0], LB'(0)}; // [R9] [R10] [R11]
        end else if (wdt_en) begin
            wdt_cnt_q <= wdt_cnt_q + 1'b1; // [R7] [R14] [R15]
        end
    end

    assign wdt_hold.req = wdt_fire; // [R8]

    wrs_hold #(
        .HOLD (WDT_PULSE_CYC)
    ) u_wdt_hold (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .hold  (wdt_hold) // [R16]
    );

    // ------------------------------------------------ reset combiner
    logic ext_req;
    logic int_rst_d;

    assign ext_req   = ~ext_rst_n_s;
    assign int_rst_d = ext_req | lv_hold.active | usb_req | wdt_hold.active; // [R17] [R1]

    // registered so the core reset never glitches on decode
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            int_rst_q <= 1'b1;
        end else begin
            int_rst_q <= int_rst_d; // [R17] [R6] [R8]
        end
    end

    assign int_reset_o = int_rst_q;

    // ------------------------------------------------ interrupt status
    logic [wrs_pkg::IRQ_W-1:0] irq_sta_q;
    logic [wrs_pkg::IRQ_W-1:0] irq_ev;
    logic [wrs_pkg::IRQ_W-1:0] irq_clr;
    logic                      lv_det_q;
    logic                      ext_req_q;
    logic                      irq_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lv_det_q  <= 1'b0;
            ext_req_q <= 1'b0;
        end else begin
            lv_det_q  <= lv_det;
            ext_req_q <= ext_req;
        end
    end

    always_comb begin
        irq_ev             = '0;
        irq_ev[wrs_pkg::IRQ_LV]  = lv_det & ~lv_det_q;
        irq_ev[wrs_pkg::IRQ_USB] = usb_det;
        irq_ev[wrs_pkg::IRQ_WDT] = wdt_fire;
        irq_ev[wrs_pkg::IRQ_EXT] = ext_req & ~ext_req_q;
    end

    assign irq_clr = (wr_stb && hit(reg_idx, wrs_pkg::REG_IRQ_CLR))
                     ? wb_dat_i[wrs_pkg::IRQ_W-1:0] : '0;

    // status survives internal resets so software can see the cause
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_sta_q <= '0;
        end else begin
            irq_sta_q <= (irq_sta_q & ~irq_clr) | irq_ev;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(irq_sta_q & irq_en_q);
        end
    end

    assign irq_o = irq_q;

    // ------------------------------------------------ read data
    logic [31:0] rd_mux;

    always_comb begin
        rd_mux = 32'h0000_0000;
        case (reg_idx)
            wrs_pkg::REG_PWR_CTL: begin
                rd_mux[7:0] = pwr_ctl_q;
            end
            wrs_pkg::REG_USB_EN: begin
                rd_mux[7:0] = usb_en_q;
            end
            wrs_pkg::REG_USB_STA: begin
                rd_mux[wrs_pkg::USB_RST_FLAG_BIT] = usb_flag_q;
            end
            wrs_pkg::REG_IRQ_STA: begin
                rd_mux[wrs_pkg::IRQ_W-1:0] = irq_sta_q;
            end
            wrs_pkg::REG_IRQ_EN: begin
                rd_mux[wrs_pkg::IRQ_W-1:0] = irq_en_q;
            end
            wrs_pkg::REG_WDT_STA: begin
                rd_mux[RB-1:0]                = wdt_cnt_q[WDT_WIDTH-1:LB];
                rd_mux[wrs_pkg::WSTA_EN_BIT]  = wdt_en;
                rd_mux[wrs_pkg::WSTA_IDLE_BIT] = idle_s;
                rd_mux[wrs_pkg::WSTA_PD_BIT]  = pd_s;
                rd_mux[wrs_pkg::WSTA_RST_BIT] = int_rst_q;
            end
            default: begin
                rd_mux = 32'h0000_0000;
            end
        endcase
    end

    // reload, key and clear registers are write-only and read as zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_q <= 32'h0000_0000;
        end else if (wb_cyc_i && wb_stb_i && !ack_q) begin
            dat_q <= wb_we_i ? 32'h0000_0000 : rd_mux;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;
endmodule : wrs_supervisor

// ---- design/wrs_sync.sv ----
`timescale 1ns/1ps
module wrs_sync #(
    parameter int           W     = 1,
    parameter logic [W-1:0] RST_V = '0
) (
    // clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // asynchronous in, synchronous out
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta_q;

    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    meta_q[g] <= RST_V[g];
                    q_o[g]    <= RST_V[g];
                end else begin
                    meta_q[g] <= d_i[g];
                    q_o[g]    <= meta_q[g];
                end
            end
        end
    endgenerate
endmodule : wrs_sync

// ---- verif/wrs_supervisor_asserts.sv ----
`timescale 1ns/1ps
module wrs_supervisor_asserts #(
    parameter int LVR_HOLD_CYC  = 50,
    parameter int WDT_PULSE_CYC = 16,
    parameter int WDT_WIDTH     = 10
) (
    // clock and reset
    input wire logic                       clk_i,
    input wire logic                       rst_i,
    // register bus
    input wire logic                       wb_cyc_i,
    input wire logic                       wb_stb_i,
    input wire logic                       wb_we_i,
    input wire logic [wrs_pkg::ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0]                 wb_sel_i,
    input wire logic [31:0]                wb_dat_i,
    input wire logic                       wb_ack_o,
    // reset sources and result
    input wire logic                       ext_reset_n_i,
    input wire logic                       lv_below_i,
    input wire logic                       usb_se0_i,
    input wire logic                       int_reset_o
);
    localparam int LIM = (1 << WDT_WIDTH) + 8;
    logic        lv_en_q;
    logic        us_en_q;
    logic        key_off_q;
    logic [9:0]  lv_cnt_q;
    logic [9:0]  quiet_q;
    logic [9:0]  run_q;
    logic [15:0] since_q;
    logic        wr;
    logic [7:0]  ix;
    assign wr = wb_ack_o & wb_we_i & wb_sel_i[0];
    assign ix = wb_adr_i[9:2];

    // shadow copies of the enables, snooped from completed writes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lv_en_q <= 1'b1;
            us_en_q <= 1'b0;
        end else if (wr && ix == wrs_pkg::REG_PWR_CTL) begin
            lv_en_q <= wb_dat_i[wrs_pkg::PWR_LVD_EN_BIT];
        end else if (wr && ix == wrs_pkg::REG_USB_EN) begin
            us_en_q <= wb_dat_i[wrs_pkg::USB_RST_EN_BIT];
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i || int_reset_o) begin
            key_off_q <= 1'b0;
        end else if (wr && ix == wrs_pkg::REG_WDT_KEY) begin
            key_off_q <= (wb_dat_i[7:0] == wrs_pkg::WDT_KEY_OFF);
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i || !lv_below_i) lv_cnt_q <= '0;
        else if (lv_cnt_q != '1) lv_cnt_q <= lv_cnt_q + 1'b1;
    end
    // quiet long enough that only the watchdog can explain a reset pulse
    always_ff @(posedge clk_i) begin
        if (rst_i || !ext_reset_n_i || lv_below_i || usb_se0_i) quiet_q <= '0;
        else if (quiet_q != '1) quiet_q <= quiet_q + 1'b1;
    end
    always_ff @(posedge clk_i) begin
        if (rst_i || !int_reset_o) run_q <= '0;
        else if (run_q != '1) run_q <= run_q + 1'b1;
    end
    always_ff @(posedge clk_i) begin
        if (rst_i || int_reset_o || (wr && ix == wrs_pkg::REG_WDT_RELOAD)) since_q <= '0;
        else if (since_q != '1) since_q <= since_q + 1'b1;
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("no ack one cycle after request");
    ext_reset_a: assert property (!ext_reset_n_i [*4] |=> int_reset_o)
        else $error("external reset not passed on");
    lv_reset_a: assert property (lv_en_q && lv_cnt_q > 10'd262 |-> int_reset_o)
        else $error("low supply gave no reset");
    lv_hold_a: assert property ((lv_en_q && lv_cnt_q > 10'd262) ##1 !lv_below_i
        |-> ##45 int_reset_o) else $error("low supply reset released early");
    usb_reset_a: assert property ((us_en_q && usb_se0_i) [*8] ##1 usb_se0_i
        |=> int_reset_o) else $error("bus reset gave no reset");
    wdt_pulse_a: assert property ($fell(int_reset_o) && quiet_q > LVR_HOLD_CYC + 14
        |-> run_q == WDT_PULSE_CYC) else $error("watchdog pulse width wrong");
    wdt_bound_a: assert property (!key_off_q |-> since_q <= LIM)
        else $error("watchdog did not fire in time");

    wdt_fire_c: cover property ($fell(int_reset_o) && quiet_q > LVR_HOLD_CYC + 14);
    lv_reset_c: cover property (lv_en_q && lv_cnt_q > 10'd262);
    usb_reset_c: cover property (us_en_q && usb_se0_i && int_reset_o);
endmodule : wrs_supervisor_asserts

bind wrs_supervisor wrs_supervisor_asserts #(
    .LVR_HOLD_CYC (LVR_HOLD_CYC),
    .WDT_PULSE_CYC(WDT_PULSE_CYC),
    .WDT_WIDTH    (WDT_WIDTH)
) u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_ack_o, .ext_reset_n_i, .lv_below_i, .usb_se0_i, .int_reset_o);

// ---- verif/wrs_supervisor_bench.sv ----
`timescale 1ns/1ps
module wrs_supervisor_bench;
    localparam int W   = 10;
    localparam int PUL = 16;
    logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, s0, hit;
    logic        ext_reset_n_i, lv_below_i, usb_se0_i, cpu_idle_i, cpu_powerdown_i;
    logic        int_reset_o, irq_o;
    logic [9:0]  wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, q;
    int          n_fail = 0, n_checks = 0, cyc_n = 0, seed = 32'ha01bcb0c, c0, n, v;

    wrs_supervisor #(.LVR_HOLD_CYC(50), .WDT_PULSE_CYC(PUL), .WDT_WIDTH(W)) uut (
        .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
        .wb_dat_o, .wb_ack_o, .ext_reset_n_i, .lv_below_i, .usb_se0_i, .cpu_idle_i,
        .cpu_powerdown_i, .int_reset_o, .irq_o);

    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    always @(posedge clk_i) cyc_n <= cyc_n + 1;

    function automatic int exp_fire(input int r);
        return (1 << W) - (r << (W - 7));
    endfunction : exp_fire

    task automatic close_out;
        $display("checks %0d errors %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : close_out

    task automatic chk1(input string nm, input logic e, input logic g);
        n_checks++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %s exp %b got %b", nm, e, g);
        end
    endtask : chk1

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask : chk

    task automatic chk_rng(input string nm, input int lo, input int hi, input int g);
        n_checks++;
        if (g < lo || g > hi) begin
            n_fail++;
            $display("[ERR] %s exp %0d..%0d got %0d", nm, lo, hi, g);
        end
    endtask : chk_rng

    // ack is read before the edge's updates land, i.e. as sampled
    task automatic bus(input logic w, input logic [7:0] ix, input logic [31:0] d);
        int t;
        t = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= w;
        wb_adr_i <= {ix, 2'b00};
        wb_sel_i <= {3'($random(seed)), s0};
        wb_dat_i <= d;
        do begin
            @(posedge clk_i);
            t++;
        end while (wb_ack_o !== 1'b1);
        chk1("ack", 1'b1, wb_ack_o);
        chk_rng("ack_lat", 2, 2, t);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask : bus

    task automatic run_len;
        n = 0;
        while (int_reset_o === 1'b1 && n < 200) begin
            @(posedge clk_i);
            n++;
        end
    endtask : run_len

    task automatic fire(input int e);
        n = 0;
        while (int_reset_o !== 1'b1 && n < 1500) begin
            @(posedge clk_i);
            n++;
        end
        chk_rng("fire", e + 1, e + 5, cyc_n - c0);
        run_len();
        chk_rng("width", PUL, PUL, n);
    endtask : fire

    task automatic hold_off(input int k);
        hit = 1'b0;
        repeat (k) begin
            @(posedge clk_i);
            if (int_reset_o !== 1'b0) hit = 1'b1;
        end
    endtask : hold_off

    task automatic pulse(input int k, input logic lv);
        if (lv) lv_below_i <= 1'b1;
        else usb_se0_i <= 1'b1;
        repeat (k) @(posedge clk_i);
        hit = int_reset_o;
        lv_below_i <= 1'b0;
        usb_se0_i  <= 1'b0;
        // one low edge so back-to-back pulses stay apart
        @(posedge clk_i);
    endtask : pulse

    task automatic irq_step(input logic [7:0] ix, input logic [31:0] d, input logic e);
        bus(1'b1, ix, d);
        repeat (2) @(posedge clk_i);
        chk1("irq", e, irq_o);
    endtask : irq_step

    initial begin
        {rst_i, ext_reset_n_i, s0} = 3'b111;
        {wb_cyc_i, wb_stb_i, wb_we_i, lv_below_i, usb_se0_i} = '0;
        {cpu_idle_i, cpu_powerdown_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
        // two edges of reset
        repeat (2) @(posedge clk_i);
        chk1("por", 1'b1, int_reset_o);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        chk1("release", 1'b0, int_reset_o);
        bus(1'b0, wrs_pkg::REG_PWR_CTL, 0);
        chk("pwr", 32'h0000_0010, q);
        s0 = 1'b0;
        bus(1'b1, wrs_pkg::REG_PWR_CTL, 0);
        s0 = 1'b1;
        bus(1'b0, wrs_pkg::REG_PWR_CTL, 0);
        chk("pwr_sel", 32'h0000_0010, q);
        bus(1'b0, wrs_pkg::REG_WDT_STA, 0);
        chk1("wdt_on", 1'b1, q[7]);
        bus(1'b0, 8'h00, 0);
        chk("unmapped", 32'h0000_0000, q);
        bus(1'b1, wrs_pkg::REG_IRQ_EN, 32'h0000_0004);
        for (int i = 0; i < 4; i++) begin
            v = (i == 0) ? 0 : (i == 1) ? 126 : $unsigned($random(seed)) % 127;
            {cpu_powerdown_i, cpu_idle_i} <= 2'($random(seed));
            bus(1'b1, wrs_pkg::REG_WDT_RELOAD, (i == 3) ? 32'h80 | v : 32'(v));
            c0 = cyc_n;
            bus(1'b0, wrs_pkg::REG_WDT_STA, 0);
            chk("msb", 32'(v), {25'h0, q[6:0]});
            chk("state", {30'h0, cpu_powerdown_i, cpu_idle_i}, {30'h0, q[9:8]});
            fire(exp_fire(v));
            chk1("irq", 1'b1, irq_o);
        end
        irq_step(wrs_pkg::REG_IRQ_EN, 0, 1'b0);
        irq_step(wrs_pkg::REG_IRQ_EN, 32'h0000_0004, 1'b1);
        irq_step(wrs_pkg::REG_IRQ_CLR, 32'h0000_0004, 1'b0);
        v = $unsigned($random(seed)) % 256;
        if (v == 'h55) v = 'h54;
        bus(1'b1, wrs_pkg::REG_WDT_RELOAD, 0);
        c0 = cyc_n;
        bus(1'b1, wrs_pkg::REG_WDT_KEY, 32'(v));
        fire(exp_fire(0));
        bus(1'b1, wrs_pkg::REG_WDT_KEY, 32'h0000_0055);
        hold_off(1500);
        chk1("key_off", 1'b0, hit);
        ext_reset_n_i <= 1'b0;
        repeat (6) @(posedge clk_i);
        chk1("ext", 1'b1, int_reset_o);
        ext_reset_n_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        bus(1'b0, wrs_pkg::REG_WDT_STA, 0);
        chk1("wdt_back", 1'b1, q[7]);
        bus(1'b1, wrs_pkg::REG_WDT_KEY, 32'h0000_0055);
        bus(1'b1, wrs_pkg::REG_USB_EN, 32'h0000_0040);
        pulse(3, 1'b0);
        bus(1'b0, wrs_pkg::REG_USB_STA, 0);
        chk1("se0_short", 1'b0, q[6]);
        pulse(12, 1'b0);
        chk1("usb_rst", 1'b1, hit);
        bus(1'b0, wrs_pkg::REG_USB_STA, 0);
        chk1("flag", 1'b1, q[6]);
        bus(1'b1, wrs_pkg::REG_USB_STA, 32'h0000_0040);
        bus(1'b0, wrs_pkg::REG_USB_STA, 0);
        chk1("flag_clr", 1'b0, q[6]);
        bus(1'b1, wrs_pkg::REG_WDT_KEY, 32'h0000_0055);
        bus(1'b1, wrs_pkg::REG_USB_EN, 0);
        pulse(12, 1'b0);
        chk1("usb_off", 1'b0, hit);
        cpu_powerdown_i <= 1'b1;
        pulse(100, 1'b1);
        chk1("dip", 1'b0, hit);
        pulse(300, 1'b1);
        chk1("lv_rst", 1'b1, hit);
        run_len();
        chk_rng("lv_hold", 50, 58, n);
        bus(1'b1, wrs_pkg::REG_WDT_KEY, 32'h0000_0055);
        bus(1'b1, wrs_pkg::REG_PWR_CTL, 0);
        pulse(300, 1'b1);
        chk1("lv_off", 1'b0, hit);
        // every source has fired by now and only the watchdog bit was ever cleared
        bus(1'b0, wrs_pkg::REG_IRQ_STA, 0);
        chk("irq_sta", 32'h0000_000F, q);
        close_out();
    end

    initial begin
        repeat (40000) @(posedge clk_i);
        n_fail++;
        close_out();
    end
endmodule : wrs_supervisor_bench
